/* handshake_if.sv */
// Interface between the role controller and one port's reset handshake engine.
`timescale 1ns/1ps
interface handshake_if;
  import usb_role_pkg::*;
  logic       enable;
  logic       request;
  logic       hostMode;
  logic       hsEnable;
  logic [1:0] lineIn;
  logic [1:0] lineOut;
  logic       lineOutEn_n;
  logic       busy;
  logic       done;
  speed_type  speed;

  modport engine (input enable, request, hostMode, hsEnable, lineIn,
                  output lineOut, lineOutEn_n, busy, done, speed);
  modport ctrl   (output enable, request, hostMode, hsEnable, lineIn,
                  input lineOut, lineOutEn_n, busy, done, speed);
endinterface : handshake_if

/* tb_usb_role_and_speed_select.sv */
// Self-checking testbench for role and speed selection on both root ports.
`timescale 1ns/1ps
module tb_usb_role_and_speed_select
  import usb_role_pkg::*;
;
  logic            core_clk, rst_n, clockSupplied, usbBlockEnable, functionSelect;
  logic            lowSpeedTransactionSelect, farReset, blockActive, hostRole, secondPortUsable, lowSpeedTraffic;
  logic [1:0]      highSpeedEnable, busResetIssue, attachLow, chirpOk, rootPortLineOutEn_n, handshakeBusy;
  logic [1:0]      handshakeDone;
  logic [1:0][1:0] rootPortLineIn, rootPortLineOut, handshakeResult;
  sched_type       scheduleMode;
  logic [2:0]      expQ[$];
  int              n_fail = 0;
  int              n_compared = 0;

  // Short counts keep the run brief; the filter of 250 cycles still fits inside them.
  usb_role_and_speed_select #(.RESET_CYC(2000), .DEV_CHIRP_LEN(500), .WAIT_CYC(3000)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .clockSupplied(clockSupplied), .usbBlockEnable(usbBlockEnable),
    .functionSelect(functionSelect), .highSpeedEnable(highSpeedEnable),
    .lowSpeedTransactionSelect(lowSpeedTransactionSelect), .busResetIssue(busResetIssue),
    .rootPortLineIn(rootPortLineIn), .rootPortLineOut(rootPortLineOut), .rootPortLineOutEn_n(rootPortLineOutEn_n),
    .blockActive(blockActive), .hostRole(hostRole), .handshakeResult(handshakeResult),
    .handshakeBusy(handshakeBusy), .handshakeDone(handshakeDone), .scheduleMode(scheduleMode),
    .secondPortUsable(secondPortUsable), .lowSpeedTraffic(lowSpeedTraffic));
  usb_far_side far (.core_clk(core_clk), .lineOut(rootPortLineOut), .lineOutEn_n(rootPortLineOutEn_n),
    .attachLow(attachLow), .chirpOk(chirpOk), .busReset(farReset), .lineIn(rootPortLineIn));

  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Each done pulse takes the oldest expected result off the queue; the falling edge sees settled outputs.
  always @(negedge core_clk) begin
    for (int p = 0; p < 2; p++)
      if (handshakeDone[p] === 1'b1) begin
        if (expQ.size() == 0)
          check("unexpected done", 4'(p), 4'hf);
        else
          check("handshake result", {1'b0, p[0], handshakeResult[p]}, {1'b0, expQ.pop_front()});
      end
  end

  // One reset handshake: host role issues it, peripheral role waits for the attached host.
  task automatic runReset(input int p, input logic high_speed_enable, input logic low, input logic ok, input speed_type exp);
    int k;
    attachLow[p] = low;
    chirpOk[p] = ok;
    step(3);
    // Software only raises high speed once the attach class is known.
    highSpeedEnable[p] = high_speed_enable;
    step(3);
    expQ.push_back({p[0], exp});
    if (functionSelect)
      busResetIssue[p] = 1'b1;
    else
      farReset = 1'b1;
    step(1);
    busResetIssue = 2'h0;
    farReset = 1'b0;
    step(1);
    // Two edges after the request the port is busy and driving SE0: busy 1, enable_n 0, line 00.
    if (functionSelect)
      check("reset drive", {handshakeBusy[p], rootPortLineOutEn_n[p], rootPortLineOut[p]}, 4'h8);
    for (k = 0; k < 8000 && handshakeDone[p] !== 1'b1; k++)
      step(1);
    check("handshake done", 4'(handshakeDone[p]), 4'h1);
    step(3500);
    $display("test reset on port %0d ended", p);
  endtask : runReset

  // Main sequence: reset, host role speeds, then peripheral role speeds.
  initial begin
    {rst_n, clockSupplied, usbBlockEnable, functionSelect, lowSpeedTransactionSelect, farReset} = 6'h0;
    {highSpeedEnable, busResetIssue, attachLow, chirpOk} = 8'h0;
    void'($urandom(32'ha86b7fe8));
    step(3);
    rst_n = 1'b1;
    check("enable_n after reset", 4'(rootPortLineOutEn_n), 4'h3);
    check("active after reset", 4'(blockActive), 4'h0);
    clockSupplied = 1'b1;
    step(2);
    // Software confirms the clock flag before it enables the block.
    wait (clockSupplied === 1'b1);
    check("active without enable", 4'(blockActive), 4'h0);
    usbBlockEnable = 1'b1;
    step(2);
    check("active", 4'(blockActive), 4'h1);
    functionSelect = ROLE_HOST;
    step(4);
    check("host role", 4'(hostRole), 4'h1);
    $display("test enable ended");
    lowSpeedTransactionSelect = 1'($urandom);
    step(3);
    check("low traffic", 4'(lowSpeedTraffic), 4'(lowSpeedTransactionSelect));
    runReset(0, 1'b0, 1'b0, 1'b0, SPEED_FULL);
    // A low-speed attach needs low-speed transactions switched on.
    lowSpeedTransactionSelect = 1'b1;
    runReset(1, 1'b0, 1'b1, 1'b0, SPEED_LOW);
    check("schedule", 4'(scheduleMode), 4'(SCHED_SHARED));
    check("low traffic on", 4'(lowSpeedTraffic), 4'h1);
    runReset(0, 1'b1, 1'b0, 1'b1, SPEED_HIGH);
    check("schedule", 4'(scheduleMode), 4'(SCHED_SEPARATE));
    runReset(1, 1'b1, 1'b0, 1'b0, SPEED_FULL);
    runReset(1, 1'b1, 1'b0, 1'b1, SPEED_HIGH);
    check("schedule", 4'(scheduleMode), 4'(SCHED_SHARED));
    check("second port", 4'(secondPortUsable), 4'h1);
    functionSelect = ROLE_PERIPH;
    step(5);
    check("peripheral role", {hostRole, secondPortUsable, scheduleMode}, 4'(SCHED_IDLE));
    check("second_root_port result", 4'(handshakeResult[1]), 4'h0);
    runReset(0, 1'b0, 1'b0, 1'b0, SPEED_FULL);
    runReset(0, 1'b1, 1'b0, 1'b1, SPEED_HIGH);
    runReset(0, 1'b1, 1'b0, 1'b0, SPEED_FULL);
    check("results left", 4'(expQ.size()), 4'h0);
    end_of_test();
  end

  // Watchdog: the tests take about 45000 cycles.
  initial begin
    #900000;
    n_fail++;
    $display("ERROR watchdog expected finish seen hang");
    end_of_test();
  end
endmodule : tb_usb_role_and_speed_select

/* usb_far_side.sv */
// Behavioural model of the attached USB peripherals on both root ports and of the attached host on the first port only.
`timescale 1ns/1ps
module usb_far_side
  import usb_role_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic [1:0][1:0] lineOut,
  input  wire logic [1:0]      lineOutEn_n,
  input  wire logic [1:0]      attachLow,
  input  wire logic [1:0]      chirpOk,
  input  wire logic            busReset,
  output logic      [1:0][1:0] lineIn
);
  int se0Cnt[2];
  int hostCnt = 100000;

  // Time the SE0 that the block drives, and the attached host's own reset sequence.
  always @(posedge core_clk) begin
    for (int p = 0; p < 2; p++)
      se0Cnt[p] <= (!lineOutEn_n[p] && lineOut[p] == LINE_SE0) ? se0Cnt[p] + 1 : 0;
    hostCnt <= busReset ? 0 : hostCnt + 1;
  end

  // Resolve each wire; the host SE0 ends early so a second reset run is never seen.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      if (chirpOk[p] && se0Cnt[p] >= 100 && se0Cnt[p] < 500)
        lineIn[p] = LINE_K;
      else if (!lineOutEn_n[p])
        lineIn[p] = lineOut[p];
      else if (p == 0 && hostCnt < 900)
        lineIn[p] = LINE_SE0;
      else if (p == 0 && chirpOk[0] && hostCnt < 3300)
        lineIn[p] = ((hostCnt - 900) / 300) % 2 ? LINE_J : LINE_K;
      else
        lineIn[p] = attachLow[p] ? LINE_K : LINE_J;
    end
  end
endmodule : usb_far_side

/* usb_reset_handshake.sv */
// Reset handshake engine for one root port, usable in host or peripheral role.
`timescale 1ns/1ps
module usb_reset_handshake
  import usb_role_pkg::*;
#(
  parameter int RESET_CYC     = RESET_DRIVE_CYC,
  parameter int DEV_CHIRP_LEN = DEV_CHIRP_CYC,
  parameter int WAIT_CYC      = CHIRP_WAIT_CYC
) (
  input wire logic    core_clk,
  input wire logic    rst_n,
  handshake_if.engine hs
);

  localparam count_type RESET_LAST = count_type'(RESET_CYC - 1);
  localparam count_type CHIRP_LAST = count_type'(DEV_CHIRP_LEN - 1);
  localparam count_type WAIT_LAST  = count_type'(WAIT_CYC - 1);

  typedef enum logic [2:0] {ST_IDLE, ST_HOST_RESET, ST_HOST_CHIRP, ST_DEV_CHIRP, ST_DEV_WAIT} state_type;

  state_type  state;
  count_type  cnt;
  count_type  chirpCnt;
  count_type  runCnt;
  logic [1:0] lastLine;
  logic [1:0] countedLine;
  logic [2:0] edges;
  logic       sawK;
  speed_type  attach;
  logic       settled;
  logic       resetOver;

  // A line level becomes valid once it has held for the settle time; one pulse per run.
  assign settled   = (runCnt == LINE_SETTLE_CYC);
  assign resetOver = (cnt == RESET_LAST);

  // Run-length filter on the received line; it saturates so settled fires once.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      runCnt   <= '0;
      lastLine <= LINE_RST;
    end else begin
      lastLine <= hs.lineIn;
      if (hs.lineIn != lastLine) begin
        runCnt <= '0;
      end else if (runCnt <= LINE_SETTLE_CYC) begin
        runCnt <= runCnt + 1'b1;
      end
    end
  end

  // Handshake sequencing; disabling the engine abandons any handshake in progress.
  always_ff @(posedge core_clk) begin
    if (!rst_n || !hs.enable) begin
      state       <= ST_IDLE;
      cnt         <= '0;
      chirpCnt    <= '0;
      lineOut_clr();
    end else begin
      hs.done <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (hs.hostMode && hs.request) begin
            // Pull-up seen before the reset: D- up is low speed, otherwise full.
            attach         <= (hs.lineIn == LINE_K) ? SPEED_LOW : SPEED_FULL;
            sawK           <= 1'b0;
            cnt            <= '0;
            hs.lineOut     <= LINE_SE0;
            hs.lineOutEn_n <= 1'b0;
            hs.busy        <= 1'b1;
            hs.speed       <= SPEED_NONE;
            state          <= ST_HOST_RESET;
          end else if (!hs.hostMode && hs.request && hs.lineIn == LINE_SE0 && settled) begin
            cnt <= '0;
            if (hs.hsEnable) begin
              hs.busy        <= 1'b1;
              hs.speed       <= SPEED_NONE;
              hs.lineOut     <= LINE_K;
              hs.lineOutEn_n <= 1'b0;
              state          <= ST_DEV_CHIRP;
            end else begin
              hs.speed <= SPEED_FULL;
              hs.done  <= 1'b1;
            end
          end
        end
        ST_HOST_RESET: begin
          cnt <= cnt + 1'b1;
          // Only a full-speed attach with high speed enabled may answer with a chirp.
          if (hs.hsEnable && attach == SPEED_FULL && hs.lineIn == LINE_K && settled) begin
            sawK <= 1'b1;
          end
          if (sawK && hs.lineIn != LINE_K) begin
            hs.lineOut <= LINE_K;
            chirpCnt   <= '0;
            state      <= ST_HOST_CHIRP;
          end
          if (resetOver) begin
            host_finish(attach);
          end
        end
        ST_HOST_CHIRP: begin
          cnt      <= cnt + 1'b1;
          chirpCnt <= chirpCnt + 1'b1;
          if (chirpCnt == HOST_CHIRP_LAST) begin
            chirpCnt   <= '0;
            hs.lineOut <= (hs.lineOut == LINE_K) ? LINE_J : LINE_K;
          end
          if (resetOver) begin
            host_finish(SPEED_HIGH);
          end
        end
        ST_DEV_CHIRP: begin
          cnt <= cnt + 1'b1;
          if (cnt == CHIRP_LAST) begin
            cnt            <= '0;
            edges          <= '0;
            countedLine    <= LINE_SE0;
            hs.lineOutEn_n <= 1'b1;
            state          <= ST_DEV_WAIT;
          end
        end
        ST_DEV_WAIT: begin
          cnt <= cnt + 1'b1;
          if (settled && (hs.lineIn == LINE_K || hs.lineIn == LINE_J) && hs.lineIn != countedLine) begin
            countedLine <= hs.lineIn;
            edges       <= edges + 1'b1;
            if (edges == CHIRP_LAST_EDGE) begin
              dev_finish(SPEED_HIGH);
            end
          end else if (cnt == WAIT_LAST) begin
            dev_finish(SPEED_FULL);
          end
        end
      endcase
    end
  end

  // Returns every driven handshake output to its idle value.
  task automatic lineOut_clr();
    hs.lineOut     <= LINE_RST;
    hs.lineOutEn_n <= 1'b1;
    hs.busy        <= 1'b0;
    hs.done        <= 1'b0;
    hs.speed       <= SPEED_NONE;
    sawK           <= 1'b0;
    attach         <= SPEED_NONE;
    edges          <= '0;
    countedLine    <= LINE_RST;
  endtask : lineOut_clr

  // Ends a host reset: release the line and publish the settled speed.
  task automatic host_finish(input speed_type result);
    hs.lineOut     <= LINE_SE0;
    hs.lineOutEn_n <= 1'b1;
    hs.busy        <= 1'b0;
    hs.done        <= 1'b1;
    hs.speed       <= result;
    state          <= ST_IDLE;
  endtask : host_finish

  // Ends a peripheral handshake with the decided speed.
  task automatic dev_finish(input speed_type result);
    hs.busy  <= 1'b0;
    hs.done  <= 1'b1;
    hs.speed <= result;
    state    <= ST_IDLE;
  endtask : dev_finish

endmodule : usb_reset_handshake

/* usb_role_and_speed_select.sv */
// Role selection, per-port speed settlement and host scheduling arrangement.
`timescale 1ns/1ps
// Notes on behaviour
// - Function select picks host or peripheral role.
// - Host, equal speed classes: one shared schedule.
// - Host, mixed speed classes: separate schedules.
// - Peripheral uses first port only, no low.
// - Host bus reset with HS runs handshake.
// - Peripheral with HS handshakes on bus reset.
// - Peripheral without HS runs full speed only.
// - Peripheral HS on success, else full speed.
// - Host without HS: D+ full, D- low.
// - Host with HS: high on success, else full, or low for a D- attach.
module usb_role_and_speed_select
  import usb_role_pkg::*;
#(
  parameter int RESET_CYC     = RESET_DRIVE_CYC,
  parameter int DEV_CHIRP_LEN = DEV_CHIRP_CYC,
  parameter int WAIT_CYC      = CHIRP_WAIT_CYC
) (
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic            clockSupplied,
  input  wire logic            usbBlockEnable,
  input  wire logic            functionSelect,
  input  wire logic [1:0]      highSpeedEnable,
  input  wire logic            lowSpeedTransactionSelect,
  input  wire logic [1:0]      busResetIssue,
  input  wire logic [1:0][1:0] rootPortLineIn,
  output logic      [1:0][1:0] rootPortLineOut,
  output logic      [1:0]      rootPortLineOutEn_n,
  output logic                 blockActive,
  output logic                 hostRole,
  output logic      [1:0][1:0] handshakeResult,
  output logic      [1:0]      handshakeBusy,
  output logic      [1:0]      handshakeDone,
  output sched_type            scheduleMode,
  output logic                 secondPortUsable,
  output logic                 lowSpeedTraffic
);

  logic            roleSettled;
  logic [1:0][1:0] engSpeed;
  logic [1:0]      engBusy;
  logic [1:0]      engDone;
  logic            sameClass;

  // The block only runs while software has enabled it and the clock is supplied.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      blockActive <= 1'b0;
    end else begin
      blockActive <= clockSupplied & usbBlockEnable;
    end
  end

  // The role follows function select; a change first idles both engines.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hostRole <= ROLE_PERIPH;
    end else if (blockActive) begin
      hostRole <= functionSelect;
    end
  end

  // Engines stay parked for the cycle in which the role is changing.
  assign roleSettled = blockActive && (hostRole == functionSelect);

  // One handshake engine per root port.
  for (genvar p = 0; p < 2; p++) begin : gen_port
    handshake_if link ();

    // The second port is unusable in peripheral role.
    assign link.enable   = roleSettled && (hostRole == ROLE_HOST || p == 0);
    // A peripheral watches for bus reset on its own; a host waits for software.
    assign link.request  = (hostRole == ROLE_HOST) ? busResetIssue[p] : 1'b1;
    assign link.hostMode = hostRole;
    assign link.hsEnable = highSpeedEnable[p];
    assign link.lineIn   = rootPortLineIn[p];

    assign rootPortLineOut[p]     = link.lineOut;
    assign rootPortLineOutEn_n[p] = link.lineOutEn_n;
    assign engSpeed[p]            = link.speed;
    assign engBusy[p]             = link.busy;
    assign engDone[p]             = link.done;

    usb_reset_handshake #(
      .RESET_CYC     (RESET_CYC),
      .DEV_CHIRP_LEN (DEV_CHIRP_LEN),
      .WAIT_CYC      (WAIT_CYC)
    ) u_handshake (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .hs       (link)
    );
  end

  // Handshake results are registered once more for the status outputs.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      handshakeResult <= {RESULT_RST, RESULT_RST};
      handshakeBusy   <= 2'h0;
      handshakeDone   <= 2'h0;
    end else begin
      handshakeResult <= engSpeed;
      handshakeBusy   <= engBusy;
      handshakeDone   <= engDone;
    end
  end

  // Both ports high speed, or both not, means one class.
  assign sameClass = ((engSpeed[0] == SPEED_HIGH) == (engSpeed[1] == SPEED_HIGH));

  // Host scheduling follows the settled classes; mixing classes needs two schedules.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scheduleMode <= SCHED_IDLE;
    end else if (!roleSettled || hostRole != ROLE_HOST) begin
      scheduleMode <= SCHED_IDLE;
    end else if (sameClass) begin
      scheduleMode <= SCHED_SHARED;
    end else begin
      scheduleMode <= SCHED_SEPARATE;
    end
  end

  // Port usability and low-speed traffic only mean anything in host role.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      secondPortUsable <= 1'b0;
      lowSpeedTraffic  <= 1'b0;
    end else begin
      secondPortUsable <= roleSettled && hostRole == ROLE_HOST;
      lowSpeedTraffic  <= roleSettled && hostRole == ROLE_HOST && lowSpeedTransactionSelect;
    end
  end

endmodule : usb_role_and_speed_select

/* usb_role_asserts.sv */
// Checker for role, speed and schedule behaviour at the block's ports.
`timescale 1ns/1ps
module usb_role_asserts
  import usb_role_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            rst_n,
  input wire logic            clockSupplied,
  input wire logic            usbBlockEnable,
  input wire logic            functionSelect,
  input wire logic [1:0]      highSpeedEnable,
  input wire logic            lowSpeedTransactionSelect,
  input wire logic [1:0]      busResetIssue,
  input wire logic [1:0][1:0] rootPortLineOut,
  input wire logic [1:0]      rootPortLineOutEn_n,
  input wire logic            blockActive,
  input wire logic            hostRole,
  input wire logic [1:0][1:0] handshakeResult,
  input wire logic [1:0]      handshakeBusy,
  input wire logic [1:0]      handshakeDone,
  input wire sched_type       scheduleMode,
  input wire logic            secondPortUsable,
  input wire logic            lowSpeedTraffic
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  block_enable_a:
  assert property ($past(rst_n) |-> blockActive == $past(clockSupplied && usbBlockEnable))
    else $error("block active does not follow the enables");
  role_follow_a:
  assert property ($past(rst_n) && $past(blockActive) |-> hostRole == $past(functionSelect))
    else $error("role does not follow function select");
  bus_reset_a:
  assert property (blockActive && hostRole && functionSelect && busResetIssue[0] && rootPortLineOutEn_n[0]
    && !handshakeBusy[0] |=> !rootPortLineOutEn_n[0] && rootPortLineOut[0] == LINE_SE0 ##1 handshakeBusy[0])
    else $error("bus reset not started");
  done_pulse_a:
  assert property (handshakeDone[0] |-> handshakeResult[0] != 2'h0 ##1 !handshakeDone[0])
    else $error("done pulse without a result");
  periph_full_a:
  assert property (handshakeDone[0] && !hostRole && !highSpeedEnable[0] |-> handshakeResult[0] == 2'h2)
    else $error("peripheral without high speed not full speed");
  periph_port_a:
  assert property ((blockActive && !hostRole)[*3] |-> rootPortLineOutEn_n[1] && handshakeResult[1] == 2'h0
    && handshakeResult[0] != 2'h1 && !secondPortUsable)
    else $error("peripheral role misuses the ports");
  periph_sched_a:
  assert property ((blockActive && !hostRole)[*4] |-> scheduleMode == SCHED_IDLE)
    else $error("schedule active in peripheral role");
  sched_mode_a:
  assert property ((blockActive && hostRole && $stable(handshakeResult))[*3] |-> scheduleMode ==
    (((handshakeResult[0] == 2'h3) == (handshakeResult[1] == 2'h3)) ? SCHED_SHARED : SCHED_SEPARATE))
    else $error("schedule arrangement wrong for port speeds");
  host_port_a:
  assert property ((blockActive && hostRole)[*3] |-> secondPortUsable)
    else $error("second port unusable in host role");
  low_traffic_a:
  assert property ((hostRole && lowSpeedTransactionSelect)[*2] |-> lowSpeedTraffic)
    else $error("low speed traffic not enabled");
endmodule : usb_role_asserts

bind usb_role_and_speed_select usb_role_asserts chk (.core_clk(core_clk), .rst_n(rst_n),
  .clockSupplied(clockSupplied), .usbBlockEnable(usbBlockEnable), .functionSelect(functionSelect),
  .highSpeedEnable(highSpeedEnable), .lowSpeedTransactionSelect(lowSpeedTransactionSelect),
  .busResetIssue(busResetIssue), .rootPortLineOut(rootPortLineOut), .rootPortLineOutEn_n(rootPortLineOutEn_n),
  .blockActive(blockActive), .hostRole(hostRole), .handshakeResult(handshakeResult),
  .handshakeBusy(handshakeBusy), .handshakeDone(handshakeDone), .scheduleMode(scheduleMode),
  .secondPortUsable(secondPortUsable), .lowSpeedTraffic(lowSpeedTraffic));

/* usb_role_pkg.sv */
// Shared constants and types for the USB role and speed selection block.
package usb_role_pkg;

  // Core clock period; every time below is converted with it.
  localparam int CLK_PERIOD_NS = 10;

  // Width of the timing counters, large enough for the longest default.
  localparam int CNT_W = 21;
  typedef logic [CNT_W-1:0] count_type;

  // Settled speed of a root port, also used as the handshake result.
  typedef enum logic [1:0] {SPEED_NONE, SPEED_LOW, SPEED_FULL, SPEED_HIGH} speed_type;

  // Host transfer scheduling arrangement.
  typedef enum logic [1:0] {SCHED_IDLE, SCHED_SHARED, SCHED_SEPARATE} sched_type;

  // Line states as {D+, D-}.
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_K   = 2'h1;
  localparam logic [1:0] LINE_J   = 2'h2;

  // Values of the function select input.
  localparam logic ROLE_HOST   = 1'h1;
  localparam logic ROLE_PERIPH = 1'h0;

  // Values after reset.
  localparam logic [1:0] RESULT_RST = 2'h0;
  localparam logic [1:0] LINE_RST   = 2'h0;

  // Times in their own units.
  localparam int RESET_DRIVE_US = 10000;
  localparam int LINE_SETTLE_NS = 2500;
  localparam int DEV_CHIRP_US   = 1000;
  localparam int HOST_CHIRP_NS  = 40000;
  localparam int CHIRP_WAIT_US  = 2000;

  // Cycle counts; least times round up.
  localparam int RESET_DRIVE_CYC = (RESET_DRIVE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEV_CHIRP_CYC   = (DEV_CHIRP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIRP_WAIT_CYC  = (CHIRP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam count_type LINE_SETTLE_CYC =
    count_type'((LINE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam count_type HOST_CHIRP_LAST =
    count_type'((HOST_CHIRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

  // Host chirp alternations a peripheral must see: three K-J pairs.
  localparam logic [2:0] CHIRP_LAST_EDGE = 3'h5;

endpackage : usb_role_pkg
